//--- rtl/sarsr_pkg.sv
// shared constants and types for the converter serial readout
`default_nettype none
package sarsr_pkg;
   localparam int unsigned RESULT_BITS   = 10;
   localparam int unsigned LEAD_ZEROS    = 4;
   localparam int unsigned FRAME_CLOCKS  = 14;
   localparam logic [4:0]  HOLD_FALL     = 5'h03;
   localparam logic [4:0]  MSB_FALL      = 5'h04;
   localparam logic [4:0]  LSB_FALL      = 5'h0d;
   localparam logic [4:0]  LOW_RISE      = 5'h10;
   localparam logic [4:0]  CNT_MAX       = 5'h1f;
   localparam logic [9:0]  RESULT_RESET  = 10'h000;
   localparam logic [9:0]  BIPOLAR_FLIP  = 10'h200;
   // host side timing
   localparam int unsigned SYS_CLK_HZ    = 25_000_000;
   localparam int unsigned SCLK_MAX_HZ   = 5_000_000;
   localparam int unsigned SCLK_MIN_HZ   = 100_000;
   localparam int unsigned ACQ_TIME_NS   = 600;
   localparam int unsigned SYS_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;
   // half period rounds up so the link clock never runs above its maximum
   localparam int unsigned HALF_DIV      =
      (SYS_CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
   localparam logic [7:0]  HALF_CNT      = 8'(HALF_DIV - 1);
   // least acquisition time in system clocks, rounded up
   localparam int unsigned ACQ_CYCLES    =
      (ACQ_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam logic [7:0]  ACQ_CNT       = 8'(ACQ_CYCLES);
   localparam logic [4:0]  FRAME_RISES   = 5'h10;

   typedef enum logic [2:0] {
      SARSR_IDLE  = 3'b000,
      SARSR_SEL   = 3'b001,
      SARSR_LOW   = 3'b010,
      SARSR_HIGH  = 3'b011,
      SARSR_END   = 3'b100
   } sarsr_host_state_t;
endpackage : sarsr_pkg
`default_nettype wire

//--- rtl/sarsr_if.sv
// link wires between converter and host
`default_nettype none
interface sarsr_if;
   logic sclk;
   logic chip_select_n;
   logic output_enable_n;
   logic polarity_select;
   logic input_channel_select;
   logic dout_o;
   logic dout_oe;

   modport device (
      input  sclk,
      input  chip_select_n,
      input  output_enable_n,
      input  polarity_select,
      input  input_channel_select,
      output dout_o,
      output dout_oe
   );
   modport host (
      output sclk,
      output chip_select_n,
      output output_enable_n,
      output polarity_select,
      output input_channel_select,
      input  dout_o,
      input  dout_oe
   );
endinterface : sarsr_if
`default_nettype wire

//--- rtl/sarsr_device.sv
// converter end: acquisition, bit sequencing and serial output
`default_nettype none
module sarsr_device #(
   parameter bit DIFFERENTIAL = 1'b1
) (
   // link
   sarsr_if.device             lnk,
   // system
   input  wire logic           reset,
   // analog stand-in: sampled codes of each input
   input  wire logic [9:0]     analog_input_first,
   input  wire logic [9:0]     analog_input_second,
   // status
   output logic                powered
);

   // frame as seen at the pin, counted from the select fall:
   //   rise 1         selects settled before this edge
   //   falls 1 to 3   output low; fall 3 freezes the sample
   //   falls 4 to 13  result bits, msb first; fall 13 powers down
   //   rise 16        last bit taken in, output forced low
   // limitation: the link clock is the only clock here, so nothing
   // moves between frames and a select fall is noticed at the next fall

   // falling-edge domain: sequencing, sample and output data
   typedef struct packed {
      logic       busy;      // conversion running
      logic       pwr;       // converter powered
      logic [4:0] falls;     // falls counted since the start fall
      logic [9:0] held;      // sample frozen on the hold fall
      logic       dbit;      // bit now on the output
      logic       cs_prev;   // select level seen at the last fall
      logic       pol;       // polarity taken at the start fall
      logic       chan;      // channel taken at the start fall
   } sarsr_dev_fall_t;

   // rising-edge domain: count of rises and the final low
   typedef struct packed {
      logic [4:0] rises;     // rises counted since the select fall
      logic       force_low; // output held low after the last capture
   } sarsr_dev_rise_t;

   // idle fall state; select reads as high, so the first fall after
   // a select fall is taken as a start
   localparam sarsr_dev_fall_t FALL_IDLE = '{
      busy:    1'b0,
      pwr:     1'b0,
      falls:   5'h00,
      held:    sarsr_pkg::RESULT_RESET,
      dbit:    1'b0,
      cs_prev: 1'b1,
      pol:     1'b0,
      chan:    1'b0
   };

   // idle rise state
   localparam sarsr_dev_rise_t RISE_IDLE = '{
      rises:     5'h00,
      force_low: 1'b0
   };

   sarsr_dev_fall_t f_q, f_d;
   sarsr_dev_rise_t r_q, r_d;
   logic [9:0]      sel_code;
   logic [9:0]      code_fmt;
   logic            start_fall;
   logic [4:0]      next_falls;
   logic            at_hold;
   logic            in_data;
   logic            at_lsb;
   logic [3:0]      bit_idx;

   // input routing: the dual single-ended variant converts the
   // channel taken at the start fall
   always_comb begin
      sel_code = f_q.chan ? analog_input_second
                          : analog_input_first;
   end

   // output coding: bipolar two's complement is the binary code with
   // its top bit inverted, so one stand-in code serves both modes;
   // the single-ended variant ignores the polarity pin
   always_comb begin
      code_fmt = sel_code;
      if (DIFFERENTIAL) begin
         if (f_q.pol)
            code_fmt = analog_input_first;
         else
            code_fmt = analog_input_first
                       ^ sarsr_pkg::BIPOLAR_FLIP;
      end
   end

   // frame decode from the fall count this edge reaches; the count
   // stops at its top so a clock that runs on never wraps it
   always_comb begin
      if (f_q.falls != sarsr_pkg::CNT_MAX)
         next_falls = f_q.falls + 5'h01;
      else
         next_falls = f_q.falls;
      at_hold = (next_falls == sarsr_pkg::HOLD_FALL);
      in_data = (next_falls >= sarsr_pkg::MSB_FALL) &&
                (next_falls <= sarsr_pkg::LSB_FALL);
      at_lsb  = (next_falls == sarsr_pkg::LSB_FALL);
      // lsb sits at index zero, so the index counts down to it
      bit_idx = 4'(sarsr_pkg::LSB_FALL - next_falls);
   end

   // a start needs select seen high at one fall and low at the next,
   // with the output enabled; select held low past the end of a
   // conversion therefore does not start another one
   assign start_fall = f_q.cs_prev && !lnk.chip_select_n &&
                       !lnk.output_enable_n;

   // sequencer: while busy every fall advances the frame and select
   // falls are ignored until the lsb edge ends the conversion
   always_comb begin
      f_d = f_q;
      f_d.cs_prev = lnk.chip_select_n;
      if (f_q.busy) begin
         f_d.falls = next_falls;
         // the sample uses the mode and channel taken at the start
         if (at_hold)
            f_d.held = code_fmt;
         // leading zeros, then msb first on each fall
         if (in_data)
            f_d.dbit = f_q.held[bit_idx];
         else
            f_d.dbit = 1'b0;
         if (at_lsb) begin
            f_d.busy = 1'b0;
            f_d.pwr  = 1'b0;
         end
      end else if (start_fall) begin
         // new frame; this fall is the first counted fall
         f_d.busy  = 1'b1;
         f_d.pwr   = 1'b1;
         f_d.falls = 5'h01;
         f_d.dbit  = 1'b0;
         f_d.pol   = lnk.polarity_select;
         f_d.chan  = lnk.input_channel_select;
      end
   end

   // oe high clears the conversion at once, whatever clock or select do
   always_ff @(negedge lnk.sclk or posedge reset
               or posedge lnk.output_enable_n) begin
      if (reset || lnk.output_enable_n) begin
         f_q <= FALL_IDLE;
      end else begin
         f_q <= f_d;
      end
   end

   // rises since the select fall: the first rise comes before the
   // start fall, so the rise after the start fall is the second
   always_comb begin
      r_d = r_q;
      if (!f_q.busy && f_q.falls == 5'h00) begin
         r_d = RISE_IDLE;
      end else if (f_q.busy && f_q.falls == 5'h01) begin
         r_d.rises = 5'h02;
      end else if (r_q.rises != sarsr_pkg::CNT_MAX) begin
         r_d.rises = r_q.rises + 5'h01;
      end
      // the sixteenth rise takes in the lsb; the output then goes low
      if (r_d.rises == sarsr_pkg::LOW_RISE)
         r_d.force_low = 1'b1;
   end

   // rise state clears with the fall state on oe high or reset
   always_ff @(posedge lnk.sclk or posedge reset
               or posedge lnk.output_enable_n) begin
      if (reset || lnk.output_enable_n) begin
         r_q <= RISE_IDLE;
      end else begin
         r_q <= r_d;
      end
   end

   // output drive: driven while oe low; after shutdown it holds the
   // lsb until rise sixteen, then drives low; with oe tied to select
   // the select rise releases the pin
   assign lnk.dout_o  = f_q.dbit & ~r_q.force_low;
   assign lnk.dout_oe = ~lnk.output_enable_n;
   // powered follows the fall state; it drops on the lsb edge
   assign powered     = f_q.pwr;
endmodule : sarsr_device
`default_nettype wire

//--- rtl/sarsr_host.sv
// host end: makes the link clock and reads one frame per request
`default_nettype none
module sarsr_host (
   // system
   input  wire logic        clk_sys,
   input  wire logic        reset,
   // request
   input  wire logic        start,
   input  wire logic        polarity_select,
   input  wire logic        input_channel_select,
   // answer
   output logic             busy,
   output logic             done,
   output logic [9:0]       result,
   output logic             lead_error,
   // link
   sarsr_if.host            lnk
);
   typedef struct packed {
      sarsr_pkg::sarsr_host_state_t st;
      logic [7:0]  div;
      logic [4:0]  rises;
      logic [13:0] shreg;
      logic        sclk;
      logic        csn;
      logic        pol;
      logic        chan;
      logic        busy;
      logic        done;
      logic [9:0]  result;
      logic        lerr;
      logic [2:0]  din_s;
      logic        din_f;
   } sarsr_host_t;

   sarsr_host_t s_q, s_d;

   // frame sequencer; clock idles low (polarity 0, phase 0)
   always_comb begin
      s_d = s_q;
      s_d.done  = 1'b0;
      s_d.din_s = {s_q.din_s[1:0], lnk.dout_o & lnk.dout_oe};
      // a new level counts once the last two stages agree
      s_d.din_f = (s_q.din_s[2] == s_q.din_s[1]) ? s_q.din_s[2]
                                                 : s_q.din_f;
      unique case (s_q.st)
         sarsr_pkg::SARSR_IDLE: begin
            s_d.sclk = 1'b0;
            s_d.csn  = 1'b1;
            if (start) begin
               s_d.st    = sarsr_pkg::SARSR_SEL;
               s_d.csn   = 1'b0;
               s_d.busy  = 1'b1;
               s_d.pol   = polarity_select;
               s_d.chan  = input_channel_select;
               s_d.rises = 5'h00;
               s_d.div   = sarsr_pkg::ACQ_CNT;
            end
         end
         // first low phase runs ACQ_CNT plus one clocks and also gives the select setup time
         sarsr_pkg::SARSR_SEL: begin
            s_d.div = s_q.div - 8'h01;
            if (s_q.div == 8'h00) begin
               s_d.st   = sarsr_pkg::SARSR_HIGH;
               s_d.sclk = 1'b1;
               s_d.div  = sarsr_pkg::HALF_CNT;
            end
         end
         sarsr_pkg::SARSR_HIGH: begin
            s_d.div = s_q.div - 8'h01;
            if (s_q.div == 8'h00) begin
               s_d.sclk = 1'b0;
               s_d.div  = sarsr_pkg::HALF_CNT;
               s_d.st   = sarsr_pkg::SARSR_LOW;
            end
         end
         sarsr_pkg::SARSR_LOW: begin
            s_d.div = s_q.div - 8'h01;
            if (s_q.div == 8'h00) begin
               s_d.rises = s_q.rises + 5'h01;
               // the filtered bit trails the pin by more than one clock
               // phase, so this rise takes the bit of the fall numbered
               // by the rise count; fall zero gives the first zero
               if (s_q.rises <= sarsr_pkg::LSB_FALL)
                  s_d.shreg = {s_q.shreg[12:0], s_q.din_f};
               s_d.div = sarsr_pkg::HALF_CNT;
               if (s_q.rises == sarsr_pkg::FRAME_RISES - 5'h01) begin
                  s_d.st = sarsr_pkg::SARSR_END;
               end else begin
                  s_d.sclk = 1'b1;
                  s_d.st   = sarsr_pkg::SARSR_HIGH;
               end
            end
         end
         sarsr_pkg::SARSR_END: begin
            s_d.st     = sarsr_pkg::SARSR_IDLE;
            s_d.csn    = 1'b1;
            s_d.busy   = 1'b0;
            s_d.done   = 1'b1;
            s_d.result = s_q.shreg[9:0];
            s_d.lerr   = |s_q.shreg[13:10];
         end
         default: s_d.st = sarsr_pkg::SARSR_IDLE;
      endcase
   end

   // one register set for the whole host
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         s_q      <= '0;
         s_q.csn  <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // oe tied to cs so the output line is shared safely
   assign lnk.sclk                 = s_q.sclk;
   assign lnk.chip_select_n        = s_q.csn;
   assign lnk.output_enable_n      = s_q.csn;
   assign lnk.polarity_select      = s_q.pol;
   assign lnk.input_channel_select = s_q.chan;
   assign busy                     = s_q.busy;
   assign done                     = s_q.done;
   assign result                   = s_q.result;
   assign lead_error               = s_q.lerr;
endmodule : sarsr_host
`default_nettype wire

//--- verif/sarsr_chk.sv
// link checker: frame timing and output enable on the wire
`default_nettype none
module sarsr_chk (
   // system
   input wire logic clk_sys,
   input wire logic reset,
   // link
   input wire logic sclk,
   input wire logic chip_select_n,
   input wire logic output_enable_n,
   input wire logic dout_o,
   input wire logic dout_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       sclk_q;
   logic [4:0] falls_q;
   logic [4:0] acq_q;
   logic       fall;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   assign fall = sclk_q & ~sclk;
   // link clock falls and cycles since select; acq saturates, no wrap
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sclk_q  <= 1'b0;
         falls_q <= 5'h00;
         acq_q   <= 5'h00;
      end else begin
         sclk_q  <= sclk;
         falls_q <= chip_select_n ? 5'h00 : falls_q + 5'(fall);
         acq_q   <= chip_select_n ? 5'h00 : acq_q + 5'(acq_q != 5'h1f);
      end
   end
   AST_OE_OFF: assert property (
      $past(output_enable_n) && output_enable_n |-> !dout_oe)
      else $error("dout driven while output enable high");
   AST_EDGE: assert property (
      dout_oe && $past(dout_oe) && $changed(dout_o) |-> fall || !dout_o)
      else $error("dout changed away from a falling edge");
   AST_ZEROS: assert property (
      dout_oe && !fall && falls_q inside {[5'h01:5'h03]} |-> !dout_o)
      else $error("leading bit not zero");
   AST_FRAME: assert property ($rose(chip_select_n) |-> falls_q >= 5'h0e)
      else $error("frame shorter than fourteen clocks");
   AST_ACQ: assert property (fall && falls_q == 5'h02 |-> acq_q >= 5'h0f)
      else $error("acquisition shorter than minimum");
   AST_TIED: assert property (output_enable_n == chip_select_n)
      else $error("output enable not tied to select");
   AST_SCLK_HI: assert property ($rose(sclk) |=> sclk [*2])
      else $error("link clock high phase too short");
   AST_SCLK_LO: assert property ($fell(sclk) |=> !sclk [*2])
      else $error("link clock low phase too short");
   AST_LOW: assert property (fall && falls_q == 5'h0f |-> !dout_o)
      else $error("output not low after the last capture");
   C_FRAME: cover property ($rose(chip_select_n));
   C_MSB: cover property (fall && falls_q == 5'h03 && dout_o);
   C_LSB: cover property (fall && falls_q == 5'h0c);
endmodule : sarsr_chk
`default_nettype wire

//--- verif/sar_adc_serial_readout_bench.sv
// bench: two host and converter pairs, one of each converter variant
`default_nettype none
module sar_adc_serial_readout_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [9:0] CODES [6] = '{10'h3ff, 10'h000, 10'h2aa,
                                        10'h155, 10'h200, 10'h1ff};
   logic       clk_sys;
   logic       reset;
   logic       start;
   logic       pol;
   logic       chan;
   logic [9:0] a1;
   logic [9:0] a2;
   logic [1:0] busy;
   logic [1:0] done;
   logic [1:0] lead;
   logic [1:0] pw;
   logic [9:0] res [2];
   int         n_errors;
   int         n_compared;
   sarsr_if i_sarsr_if ();
   sarsr_if i_sarsr_if_s ();
   sarsr_host i_sarsr_host (.clk_sys(clk_sys), .reset(reset), .start(start),
      .polarity_select(pol), .input_channel_select(chan), .busy(busy[0]),
      .done(done[0]), .result(res[0]), .lead_error(lead[0]),
      .lnk(i_sarsr_if));
   sarsr_device #(.DIFFERENTIAL(1'b1)) i_sarsr_device (.lnk(i_sarsr_if),
      .reset(reset), .analog_input_first(a1), .analog_input_second(a2),
      .powered(pw[0]));
   sarsr_host i_sarsr_host_s (.clk_sys(clk_sys), .reset(reset),
      .start(start), .polarity_select(pol), .input_channel_select(chan),
      .busy(busy[1]), .done(done[1]), .result(res[1]), .lead_error(lead[1]),
      .lnk(i_sarsr_if_s));
   sarsr_device #(.DIFFERENTIAL(1'b0)) i_sarsr_device_s (.lnk(i_sarsr_if_s),
      .reset(reset), .analog_input_first(a1), .analog_input_second(a2),
      .powered(pw[1]));
   sarsr_chk i_sarsr_chk (.clk_sys(clk_sys), .reset(reset),
      .sclk(i_sarsr_if.sclk), .chip_select_n(i_sarsr_if.chip_select_n),
      .output_enable_n(i_sarsr_if.output_enable_n),
      .dout_o(i_sarsr_if.dout_o), .dout_oe(i_sarsr_if.dout_oe));
   // system clock, 40 ns
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic check(input string what, input logic [9:0] seen,
                        input logic [9:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim
   // one frame on both pairs; start is a one-cycle request
   task automatic run(input logic p, input logic c, input logic [9:0] x,
                      input logic [9:0] y);
      int k;
      @(posedge clk_sys);
      pol   <= p;
      chan  <= c;
      a1    <= x;
      a2    <= y;
      start <= 1'b1;
      @(posedge clk_sys);
      start <= 1'b0;
      k = 0;
      while (done[0] !== 1'b1 && k < 400) begin
         @(posedge clk_sys);
         #1;
         k++;
      end
      check("done", {8'h00, done}, 10'h003);
      check("result diff", res[0], p ? x : {~x[9], x[8:0]});
      check("result chan", res[1], c ? y : x);
      check("lead zeros", {8'h00, lead}, 10'h000);
      check("powered", {8'h00, pw}, 10'h000);
   endtask : run
   // main sequence
   initial begin
      n_errors   = 0;
      n_compared = 0;
      reset      = 1'b1;
      start      = 1'b0;
      pol        = 1'b1;
      chan       = 1'b0;
      a1         = 10'h000;
      a2         = 10'h000;
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      // back-to-back frames, every polarity and channel choice
      for (int i = 0; i < 6; i++) begin
         run(i[0], i[1], CODES[i], ~CODES[i]);
      end
      $display("test codes done");
      // reset in mid frame must abort and release the line
      @(posedge clk_sys);
      start <= 1'b1;
      @(posedge clk_sys);
      start <= 1'b0;
      repeat (60) @(posedge clk_sys);
      #1;
      check("powered mid frame", {8'h00, pw}, 10'h003);
      @(posedge clk_sys);
      reset <= 1'b1;
      @(posedge clk_sys);
      reset <= 1'b0;
      #1;
      check("after reset", {6'h00, busy, i_sarsr_if.output_enable_n,
            i_sarsr_if.dout_oe}, 10'h002);
      run(1'b1, 1'b0, 10'h155, 10'h2aa);
      $display("test abort done");
      end_sim();
   end
   // watchdog well past eight frames
   initial begin
      repeat (3000) @(posedge clk_sys);
      n_errors++;
      $display("BAD watchdog expected finish seen hang");
      end_sim();
   end
endmodule : sar_adc_serial_readout_bench
`default_nettype wire
